// ===== rcr_irq_ctrl.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "rcr_regs.svh"

// Operation
// R01 - Bit 7 selects set or clear of marked flags
// R02 - Timer flag sets when count reaches zero
// R03 - Transmit flag sets on any data-done event
// R04 - Receive flag sets when receiver finishes
// R05 - Idle flag sets on correct command end
// R06 - Idle flag sets on unknown command start
// R07 - Host idle start leaves idle flag alone
// R08 - High flag sets when high status rises
// R09 - Low flag sets when low status rises
// R10 - Alert flags latch until software clears
// R11 - Request and control registers reset zero
// R12 - Control bit 5 enters standby
// R13 - Control bit 4 enters power-down
// R14 - Control bit 3 shows cipher state
// R15 - Cipher set only by second auth success
// R16 - Control bit 2 stops the timer
// R17 - Control bit 1 starts the timer
// R18 - Control bit 0 flushes the FIFO
// R19 - Strobe bits always read zero
// R20 - Enabled flags drive the interrupt pin
// R21 - High and low status from count, threshold
// R22 - Reserved bits have no effect
module rcr_irq_ctrl
  import rcr_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Host register port
  input  wire logic [`RCR_ADDR_W-1:0]   reg_addr,
  input  wire logic [`RCR_DATA_W-1:0]   reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [`RCR_DATA_W-1:0]   reg_rdata,
  // Timer engine
  input  wire logic [`RCR_TIMER_W-1:0]  timer_count,
  output logic                          timer_stop_strobe,
  output logic                          timer_start_strobe,
  // Command engine events
  input  wire logic                     transceive_sent,
  input  wire logic                     auth_data_sent,
  input  wire logic                     nvm_write_done,
  input  wire logic                     checksum_done,
  input  wire logic                     receive_finished,
  input  wire logic                     command_end_idle,
  input  wire logic                     host_idle_start,
  input  wire logic                     unknown_command_start,
  input  wire logic                     auth_step_two_ok,
  // FIFO engine
  input  wire logic [`RCR_COUNT_W-1:0]  fifo_byte_count,
  output logic                          fifo_flush_strobe,
  output logic                          fifo_high_status,
  output logic                          fifo_low_status,
  // Power and cipher
  output logic                          standby,
  output logic                          power_down_request,
  output logic                          cipher_active,
  // Interrupt pin
  output logic                          irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  rcr_state_t st_reg;
  rcr_state_t st_next;

  logic                    wr_req;
  logic                    wr_ctl;
  logic                    wr_en;
  logic                    wr_thr;
  logic                    set_sel;
  logic [`RCR_FLAG_W-1:0]  mark;
  logic [`RCR_FLAG_W-1:0]  hw_set;
  logic                    high_now;
  logic                    low_now;
  logic [`RCR_COUNT_W-1:0] room;
  logic [`RCR_COUNT_W-1:0] thr_wide;

  // Next values per field
  logic [`RCR_FLAG_W-1:0]  flag_next;
  logic [`RCR_FLAG_W-1:0]  enable_next;
  logic [`RCR_THR_W-1:0]   threshold_next;
  logic                    standby_next;
  logic                    power_down_next;
  logic                    cipher_next;
  logic                    tstop_next;
  logic                    tstart_next;
  logic                    flush_next;
  logic                    irq_next;

  // Event pulses
  logic                    timer_event;
  logic                    tx_event;
  logic                    rx_event;
  logic                    idle_event;
  logic                    high_event;
  logic                    low_event;

  // Read words
  logic [`RCR_DATA_W-1:0]  req_word;
  logic [`RCR_DATA_W-1:0]  en_word;
  logic [`RCR_DATA_W-1:0]  ctl_word;
  logic [`RCR_DATA_W-1:0]  stat_word;
  logic [`RCR_DATA_W-1:0]  thr_word;
  logic [`RCR_DATA_W-1:0]  rd_word;

  // ****************************************************************
  // Write decode
  // ****************************************************************
  always_comb begin
    wr_req = reg_wr && (reg_addr == `RCR_OFS_IRQ_REQ);
    wr_ctl = reg_wr && (reg_addr == `RCR_OFS_CONTROL);
    wr_en  = reg_wr && (reg_addr == `RCR_OFS_IRQ_EN);
    wr_thr = reg_wr && (reg_addr == `RCR_OFS_THRESHOLD);
  end

  // Bit 7 picks set or clear; the low six bits mark the flags
  always_comb begin
    set_sel = reg_wdata[`RCR_SET_SEL_BIT];
    mark    = reg_wdata[`RCR_FLAG_W-1:0];
  end

  // ****************************************************************
  // FIFO room
  // ****************************************************************
  // A count above the depth wraps the subtraction, so high status
  // stays off for a faulty engine rather than asserting falsely
  always_comb begin
    thr_wide = {1'b0, st_reg.threshold};
    room     = `RCR_FIFO_DEPTH - fifo_byte_count;
  end

  // ****************************************************************
  // FIFO level status
  // ****************************************************************
  always_comb begin
    high_now = (room <= thr_wide);                      // [R21]
    low_now  = (fifo_byte_count <= thr_wide);           // [R21]
  end

  // ****************************************************************
  // Hardware events
  // ****************************************************************
  // Timer flag fires on the nonzero-to-zero step only, so a timer
  // resting at zero does not raise again a flag software cleared
  always_comb begin
    timer_event = st_reg.timer_nonzero && (timer_count == '0);   // [R02]
  end

  // Any of the four data-done events marks the transmit flag
  always_comb begin
    tx_event = transceive_sent
               || auth_data_sent
               || nvm_write_done
               || checksum_done;                                  // [R03]
  end

  always_comb begin
    rx_event = receive_finished;                                  // [R04]
  end

  // A host-started idle command masks the end-of-command event
  always_comb begin
    idle_event = (command_end_idle && !host_idle_start)          // [R05] [R07]
                 || unknown_command_start;                        // [R06]
  end

  // Alert flags take the rising edge of the level status only
  always_comb begin
    high_event = high_now && !st_reg.high_status;                 // [R08]
    low_event  = low_now && !st_reg.low_status;                   // [R09]
  end

  // Gather the events into flag order
  always_comb begin
    hw_set                  = '0;
    hw_set[`RCR_FLAG_TIMER] = timer_event;
    hw_set[`RCR_FLAG_TX]    = tx_event;
    hw_set[`RCR_FLAG_RX]    = rx_event;
    hw_set[`RCR_FLAG_IDLE]  = idle_event;
    hw_set[`RCR_FLAG_HIGH]  = high_event;
    hw_set[`RCR_FLAG_LOW]   = low_event;
  end

  // ****************************************************************
  // Request and enable bits
  // ****************************************************************
  // A hardware set in the same cycle as a software clear wins, so an
  // event is never lost to a clear that races it
  genvar gi;
  generate
    for (gi = 0; gi < `RCR_FLAG_W; gi = gi + 1) begin : g_bit
      always_comb begin
        flag_next[gi] = st_reg.flags[gi];
        if (wr_req && mark[gi]) begin
          flag_next[gi] = set_sel;                                // [R01]
        end
        if (hw_set[gi]) begin
          flag_next[gi] = 1'b1;                                   // [R10]
        end
      end

      always_comb begin
        enable_next[gi] = st_reg.enable[gi];
        if (wr_en && mark[gi]) begin
          enable_next[gi] = set_sel;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Threshold
  // ****************************************************************
  always_comb begin
    threshold_next = st_reg.threshold;
    if (wr_thr) begin
      threshold_next = reg_wdata[`RCR_THR_W-1:0];
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Power bits are plain stored levels; writing 0 wakes the device
  always_comb begin
    standby_next    = st_reg.standby;
    power_down_next = st_reg.power_down;
    if (wr_ctl) begin
      standby_next    = reg_wdata[`RCR_CTL_STANDBY];              // [R12]
      power_down_next = reg_wdata[`RCR_CTL_POWER_DOWN];           // [R13]
    end
  end

  // Strobes last one cycle and are never stored for reading
  always_comb begin
    tstop_next  = 1'b0;
    tstart_next = 1'b0;
    flush_next  = 1'b0;
    if (wr_ctl) begin
      tstop_next  = reg_wdata[`RCR_CTL_TSTOP];                    // [R16]
      tstart_next = reg_wdata[`RCR_CTL_TSTART];                   // [R17]
      flush_next  = reg_wdata[`RCR_CTL_FLUSH];                    // [R18]
    end
  end

  // ****************************************************************
  // Cipher state
  // ****************************************************************
  // Software may only switch the cipher off; a successful second
  // authentication step switches it on and wins over a clear
  always_comb begin
    cipher_next = st_reg.cipher;
    if (wr_ctl && !reg_wdata[`RCR_CTL_CIPHER]) begin
      cipher_next = 1'b0;                                         // [R15]
    end
    if (auth_step_two_ok) begin
      cipher_next = 1'b1;                                         // [R14] [R15]
    end
  end

  // ****************************************************************
  // Interrupt pin
  // ****************************************************************
  // Built from next values so the pin moves in the cycle of the flag
  always_comb begin
    irq_next = |(flag_next & enable_next);                        // [R20]
  end

  // ****************************************************************
  // Read words
  // ****************************************************************
  // Reserved bits and write-only strobe bits always read as zero
  always_comb begin
    req_word  = {2'b00, st_reg.flags};                            // [R22]
    en_word   = {2'b00, st_reg.enable};
    ctl_word  = {2'b00, st_reg.standby, st_reg.power_down,
                 st_reg.cipher, 3'b000};                          // [R19] [R22]
    stat_word = {6'h00, st_reg.high_status, st_reg.low_status};
    thr_word  = {2'b00, st_reg.threshold};
  end

  // Unmapped offsets read as zero
  always_comb begin
    case (reg_addr)
      `RCR_OFS_IRQ_REQ: begin
        rd_word = req_word;
      end
      `RCR_OFS_IRQ_EN: begin
        rd_word = en_word;
      end
      `RCR_OFS_CONTROL: begin
        rd_word = ctl_word;
      end
      `RCR_OFS_FIFO_STAT: begin
        rd_word = stat_word;
      end
      `RCR_OFS_THRESHOLD: begin
        rd_word = thr_word;
      end
      default: begin
        rd_word = `RCR_RST_BYTE;
      end
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next               = st_reg;
    st_next.flags         = flag_next;
    st_next.enable        = enable_next;
    st_next.threshold     = threshold_next;
    st_next.standby       = standby_next;
    st_next.power_down    = power_down_next;
    st_next.cipher        = cipher_next;
    st_next.tstop         = tstop_next;
    st_next.tstart        = tstart_next;
    st_next.flush         = flush_next;
    st_next.irq           = irq_next;
    st_next.high_status   = high_now;
    st_next.low_status    = low_now;
    st_next.timer_nonzero = (timer_count != '0);
    // Read data stands only in the cycle after the read strobe
    st_next.rd_data       = `RCR_RST_BYTE;
    if (reg_rd) begin
      st_next.rd_data = rd_word;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg               <= '0;                        // [R11]
      st_reg.flags         <= `RCR_RST_FLAGS;
      st_reg.enable        <= `RCR_RST_ENABLE;
      st_reg.threshold     <= `RCR_RST_THRESHOLD;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    reg_rdata          = st_reg.rd_data;
    timer_stop_strobe  = st_reg.tstop;
    timer_start_strobe = st_reg.tstart;
    fifo_flush_strobe  = st_reg.flush;
    fifo_high_status   = st_reg.high_status;
    fifo_low_status    = st_reg.low_status;
    standby            = st_reg.standby;
    power_down_request = st_reg.power_down;
    cipher_active      = st_reg.cipher;
    irq                = st_reg.irq;
  end

endmodule

// ===== rcr_regs.svh
`ifndef RCR_REGS_SVH
`define RCR_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RCR_ADDR_W          6
`define RCR_DATA_W          8
`define RCR_OFS_IRQ_EN      6'h06
`define RCR_OFS_IRQ_REQ     6'h07
`define RCR_OFS_CONTROL     6'h09
`define RCR_OFS_FIFO_STAT   6'h3d
`define RCR_OFS_THRESHOLD   6'h3e

// ****************************************************************
// Request and enable fields
// ****************************************************************
`define RCR_SET_SEL_BIT     7
`define RCR_FLAG_W          6
`define RCR_FLAG_TIMER      5
`define RCR_FLAG_TX         4
`define RCR_FLAG_RX         3
`define RCR_FLAG_IDLE       2
`define RCR_FLAG_HIGH       1
`define RCR_FLAG_LOW        0

// ****************************************************************
// Control fields
// ****************************************************************
`define RCR_CTL_STANDBY     5
`define RCR_CTL_POWER_DOWN  4
`define RCR_CTL_CIPHER      3
`define RCR_CTL_TSTOP       2
`define RCR_CTL_TSTART      1
`define RCR_CTL_FLUSH       0

// ****************************************************************
// Reset values and FIFO geometry
// ****************************************************************
`define RCR_RST_FLAGS       6'h00
`define RCR_RST_ENABLE      6'h00
`define RCR_RST_BYTE        8'h00
`define RCR_RST_THRESHOLD   6'h08
`define RCR_FIFO_DEPTH      7'h40
`define RCR_COUNT_W         7
`define RCR_THR_W           6
`define RCR_TIMER_W         8

`endif

// ===== rcr_pkg.sv
`include "rcr_regs.svh"

package rcr_pkg;

  // ****************************************************************
  // Complete state of the register block
  // ****************************************************************
  typedef struct packed {
    logic [`RCR_FLAG_W-1:0]  flags;
    logic [`RCR_FLAG_W-1:0]  enable;
    logic [`RCR_THR_W-1:0]   threshold;
    logic                    standby;
    logic                    power_down;
    logic                    cipher;
    logic                    tstop;
    logic                    tstart;
    logic                    flush;
    logic                    irq;
    logic                    high_status;
    logic                    low_status;
    logic                    timer_nonzero;
    logic [`RCR_DATA_W-1:0]  rd_data;
  } rcr_state_t;

endpackage

// ===== rcr_irq_monitor.sv
`timescale 1ns/1ps
`include "rcr_regs.svh"
module rcr_irq_monitor (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_n,
  // Host port
  input wire logic [`RCR_ADDR_W-1:0] reg_addr,
  input wire logic [`RCR_DATA_W-1:0] reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [`RCR_DATA_W-1:0] reg_rdata,
  // Engine side
  input wire logic                   auth_step_two_ok,
  input wire logic                   timer_stop_strobe,
  input wire logic                   timer_start_strobe,
  input wire logic                   fifo_flush_strobe,
  input wire logic                   standby,
  input wire logic                   power_down_request,
  input wire logic                   cipher_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ctl_wr;
    reg_wr && reg_addr == `RCR_OFS_CONTROL;
  endsequence
  sequence s_ctl_rd;
    reg_rd && reg_addr == `RCR_OFS_CONTROL;
  endsequence
  property p_stop;  s_ctl_wr |=> timer_stop_strobe == $past(reg_wdata[2]); endproperty
  property p_start; s_ctl_wr |=> timer_start_strobe == $past(reg_wdata[1]); endproperty
  property p_flush; s_ctl_wr |=> fifo_flush_strobe == $past(reg_wdata[0]); endproperty
  property p_stby;  s_ctl_wr |=> standby == $past(reg_wdata[5]); endproperty
  property p_pdown; s_ctl_wr |=> power_down_request == $past(reg_wdata[4]); endproperty
  property p_rdz;   s_ctl_rd |=> reg_rdata[2:0] == 3'h0; endproperty
  property p_rst;   !$past(rst_n) |-> !standby && !power_down_request && !cipher_active;
  endproperty
  property p_ciph;  $rose(cipher_active) |-> $past(auth_step_two_ok); endproperty
  a_stop:  assert property (p_stop)  else $error("timer stop strobe wrong");
  a_start: assert property (p_start) else $error("timer start strobe wrong");
  a_flush: assert property (p_flush) else $error("flush strobe wrong");
  a_stby:  assert property (p_stby)  else $error("standby wrong");
  a_pdown: assert property (p_pdown) else $error("power down wrong");
  a_rdz:   assert property (p_rdz)   else $error("strobe bits read nonzero");
  a_rst:   assert property (p_rst)   else $error("control not zero from reset");
  a_ciph:  assert property (p_ciph)  else $error("cipher set without auth");
endmodule

// ===== rcr_host_model.sv
`timescale 1ns/1ps
`include "rcr_regs.svh"
module rcr_host_model (
  // Clock
  input wire logic                   clk,
  // Host port
  output logic     [`RCR_ADDR_W-1:0] reg_addr,
  output logic     [`RCR_DATA_W-1:0] reg_wdata,
  output logic                       reg_wr,
  output logic                       reg_rd,
  input wire logic [`RCR_DATA_W-1:0] reg_rdata
);
  initial begin
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Released lines show the inverse so stale values never pass
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
`include "rcr_regs.svh"
module tb_top;
  import rcr_pkg::*;
  logic       clk, rst_n, reg_wr, reg_rd, irq, t_stop, t_start, flush, hi, lo, sb, pd, cph_o;
  logic [5:0] reg_addr, fl, en;
  logic [7:0] reg_wdata, reg_rdata, timer_count;
  logic [6:0] fifo_byte_count;
  logic [8:0] ev;
  logic [31:0] w;
  logic       cph;
  int         i, n_fail, checked, seed = 42053;
  rcr_host_model host_inst (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  rcr_irq_ctrl rcr_irq_ctrl_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_count(timer_count), .timer_stop_strobe(t_stop), .timer_start_strobe(t_start),
    .transceive_sent(ev[0]), .auth_data_sent(ev[1]), .nvm_write_done(ev[2]),
    .checksum_done(ev[3]), .receive_finished(ev[4]), .command_end_idle(ev[5]),
    .unknown_command_start(ev[6]), .host_idle_start(ev[7]), .auth_step_two_ok(ev[8]),
    .fifo_byte_count(fifo_byte_count), .fifo_flush_strobe(flush), .fifo_high_status(hi),
    .fifo_low_status(lo), .standby(sb), .power_down_request(pd), .cipher_active(cph_o),
    .irq(irq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_inst.rd(a, d);
    chk("rdata", d, e);
  endtask
  task automatic pulse(input logic [8:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 9'h000;
  endtask
  task automatic setc(input logic [6:0] v);
    @(posedge clk);
    fifo_byte_count <= v;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic final_report;
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #50000;
    n_fail++;
    final_report;
  end
  initial begin
    rst_n = 1'b0;
    ev = 9'h000;
    timer_count = 8'h05;
    fifo_byte_count = 7'h20;
    fl = 6'h00;
    en = 6'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(`RCR_OFS_IRQ_REQ, 8'h00);
    rdchk(`RCR_OFS_CONTROL, 8'h00);
    rdchk(6'h15, 8'h00);
    for (i = 0; i < 24; i++) begin
      w = $random(seed);
      host_inst.wr(w[8] ? `RCR_OFS_IRQ_EN : `RCR_OFS_IRQ_REQ, w[7:0]);
      if (w[8]) en = w[7] ? (en | w[5:0]) : (en & ~w[5:0]);
      else fl = w[7] ? (fl | w[5:0]) : (fl & ~w[5:0]);
      chk("irq", {7'h00, irq}, {7'h00, |(fl & en)});
      rdchk(`RCR_OFS_IRQ_REQ, {2'b00, fl});
    end
    for (i = 0; i < 8; i++) begin
      host_inst.wr(`RCR_OFS_IRQ_REQ, 8'h3f);
      pulse(i == 7 ? 9'h0a0 : 9'h001 << i);
      w = (i == 7) ? 32'h0 : 32'h1 << (i < 4 ? 4 : i == 4 ? 3 : 2);
      rdchk(`RCR_OFS_IRQ_REQ, w[7:0]);
    end
    host_inst.wr(`RCR_OFS_IRQ_REQ, 8'h3f);
    @(posedge clk);
    timer_count <= 8'h00;
    rdchk(`RCR_OFS_IRQ_REQ, 8'h20);
    host_inst.wr(`RCR_OFS_IRQ_REQ, 8'h20);
    setc(7'h04);
    chk("low", {7'h00, lo}, 8'h01);
    setc(7'h20);
    rdchk(`RCR_OFS_IRQ_REQ, 8'h01);
    setc(7'h3c);
    chk("high", {7'h00, hi}, 8'h01);
    setc(7'h20);
    rdchk(`RCR_OFS_IRQ_REQ, 8'h03);
    host_inst.wr(`RCR_OFS_IRQ_REQ, 8'h43);
    rdchk(`RCR_OFS_IRQ_REQ, 8'h00);
    pulse(9'h100);
    cph = 1'b1;
    for (i = 0; i < 16; i++) begin
      w = $random(seed);
      host_inst.wr(`RCR_OFS_CONTROL, w[7:0]);
      chk("strobes", {5'h00, t_stop, t_start, flush}, {5'h00, w[2:0]});
      cph = cph & w[3];
      rdchk(`RCR_OFS_CONTROL, {2'b00, w[5:4], cph, 3'b000});
      chk("power", {5'h00, sb, pd, cph_o}, {5'h00, w[5:4], cph});
    end
    host_inst.wr(`RCR_OFS_CONTROL, 8'h00);
    final_report;
  end
endmodule
bind rcr_irq_ctrl rcr_irq_monitor rcr_irq_monitor_inst (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .auth_step_two_ok(auth_step_two_ok),
  .timer_stop_strobe(timer_stop_strobe), .timer_start_strobe(timer_start_strobe),
  .fifo_flush_strobe(fifo_flush_strobe), .standby(standby),
  .power_down_request(power_down_request), .cipher_active(cipher_active));
